// ---- inc/wiper_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Serial link between host and potentiometer
interface wiper_link_if;
	logic cs_n;
	logic sck;
	logic sdi;
	logic sdo;
	modport device (input cs_n, input sck, input sdi, output sdo);
	modport host (output cs_n, output sck, output sdi, input sdo);
endinterface
`default_nettype wire

// ---- inc/wiper_pkg.sv ----
// How it works
// (R1) Chained increments only to wiper address zero
// (R2) Each chained increment adds exactly one
// (R3) Increment saturates at full-scale, FFh or 7Fh
// (R4) Host may chain step commands freely
// (R5) Any valid command may follow a step
// (R6) Eight clocks per command; wiper moves at eighth
// (R7) Chained decrements only to wiper address zero
// (R8) Each chained decrement subtracts exactly one
// (R9) Decrement at zero-scale leaves value unchanged
// (R10) Error flag driven on serial output clock seven
// (R11) After error, output stays low until deselect
// (R12) Decrement accepted only while select is low
// (R13) Single step needs just the command byte
// (R14) Step to other address flags command error
// (R15) Host deselects promptly after the last step
// (R16) No increment past full-scale; others step
// (R17) Command cut short leaves wiper untouched
package wiper_pkg;
	localparam int BITS_PER_CMD = 8;
	localparam int ERR_BIT_INDEX = 6;
	localparam logic [3:0] WIPER_ADDR = 4'h0;
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_INCR = 2'h1;
	localparam logic [1:0] OP_DECR = 2'h2;
	localparam logic [1:0] OP_READ = 2'h3;
	localparam logic [7:0] FULL_SCALE_8 = 8'hFF;
	localparam logic [7:0] FULL_SCALE_7 = 8'h7F;
	localparam logic [7:0] ZERO_SCALE = 8'h00;
	localparam logic [7:0] WIPER_RESET = 8'h80;
	localparam logic [7:0] WIPER_RESET_7 = 8'h40;
	localparam int LINK_DIV = 4;
	localparam logic [2:0] LINK_DIV_LAST = 3'h3;
	localparam logic [2:0] LINK_DIV_HALF = 3'h1;
	localparam logic [7:0] CMD_WIDTH_LAST = 8'h07;
endpackage

// ---- src/wiper_device.sv ----
`timescale 1ns/1ps
`default_nettype none
module wiper_device
	import wiper_pkg::*;
#(
	parameter bit SEVEN_BIT = 1'b0
)(
	input wire logic CLOCK,
	input wire logic RST,
	wiper_link_if.device LINK,
	output logic [7:0] WIPER,
	output logic STEP_DONE,
	output logic CMD_ERROR
);
	import wiper_pkg::*;

	// Saturated step of the wiper value
	function automatic logic [7:0] step_value(input logic [7:0] v, input logic up,
		input logic seven);
		logic [7:0] top;
		top = seven ? FULL_SCALE_7 : FULL_SCALE_8;
		if (up)
			step_value = (v >= top) ? top : v + 8'h01; // see (R2) (R3) (R16)
		else
			step_value = (v == ZERO_SCALE) ? v : v - 8'h01; // see (R8) (R9)
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: first stage is read only by the second
	logic [2:0] cs_s1_q, cs_s2_q;
	logic [2:0] sync_d;
	logic sck_prev_q, sck_prev_d;
	always_comb
	begin
		sync_d = {LINK.cs_n, LINK.sck, LINK.sdi};
		sck_prev_d = cs_s2_q[1];
	end
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			cs_s1_q <= 3'h4;
			cs_s2_q <= 3'h4;
			sck_prev_q <= 1'b0;
		end
		else
		begin
			cs_s1_q <= sync_d;
			cs_s2_q <= cs_s1_q;
			sck_prev_q <= sck_prev_d;
		end
	end
	logic cs_n_s, sck_rise, sck_fall, sdi_s;
	assign cs_n_s = cs_s2_q[2];
	assign sdi_s = cs_s2_q[0];
	assign sck_rise = cs_s2_q[1] & ~sck_prev_q;
	assign sck_fall = ~cs_s2_q[1] & sck_prev_q;

	////////////////////////////////////////////////////////////////////////
	// Command shifter, error latch and wiper
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] shift_q, shift_d;
	logic err_q, err_d;
	logic sdo_q, sdo_d;
	logic [7:0] wiper_q, wiper_d;
	logic done_q, done_d;
	logic [7:0] cmd;
	logic cmd_ok;
	always_comb
	begin
		cnt_d = cnt_q;
		shift_d = shift_q;
		err_d = err_q;
		sdo_d = sdo_q;
		wiper_d = wiper_q;
		done_d = 1'b0;
		cmd = {shift_q[6:0], sdi_s};
		// Only steps to the wiper are valid here; write and read are not built
		cmd_ok = (shift_q[5:2] == WIPER_ADDR) &&
			((shift_q[1:0] == OP_INCR) || (shift_q[1:0] == OP_DECR)); // see (R1) (R7) (R14)
		if (cs_n_s)
		begin
			// Deselect drops a partial command and clears the error
			cnt_d = 3'h0; // see (R17)
			err_d = 1'b0; // see (R11)
			sdo_d = 1'b1;
		end
		else
		begin
			if (sck_rise) // see (R12)
			begin
				shift_d = cmd;
				cnt_d = cnt_q + 3'h1; // see (R4) (R5)
				if (cnt_q == 3'(BITS_PER_CMD - 1) && !err_q &&
					cmd[3:2] != OP_WRITE && cmd[3:2] != OP_READ)
				begin
					// Wiper moves on the eighth clock; no data byte follows
					wiper_d = step_value(wiper_q, cmd[3:2] == OP_INCR, SEVEN_BIT); // see (R6) (R13)
					done_d = 1'b1;
				end
			end
			if (sck_fall)
			begin
				// Flag appears after the sixth bit, i.e. during clock seven
				if (cnt_q == 3'(ERR_BIT_INDEX) && !cmd_ok)
				begin
					err_d = 1'b1;
					sdo_d = 1'b0; // see (R10)
				end
				else
					sdo_d = ~err_q; // see (R11)
			end
		end
	end
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			cnt_q <= 3'h0;
			shift_q <= 8'h00;
			err_q <= 1'b0;
			sdo_q <= 1'b1;
			// A seven-bit part must come up inside its own range, or its first step jumps
			wiper_q <= SEVEN_BIT ? WIPER_RESET_7 : WIPER_RESET;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			err_q <= err_d;
			sdo_q <= sdo_d;
			wiper_q <= wiper_d;
			done_q <= done_d;
		end
	end
	assign LINK.sdo = sdo_q;
	assign WIPER = wiper_q;
	assign STEP_DONE = done_q;
	assign CMD_ERROR = err_q;
endmodule // wiper_device
`default_nettype wire

// ---- src/wiper_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module wiper_host
	import wiper_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	wiper_link_if.host LINK,
	input wire logic START,
	input wire logic [7:0] COMMAND,
	input wire logic LAST,
	output logic BUSY,
	output logic NEXT,
	output logic ERROR_SEEN
);
	import wiper_pkg::*;

	typedef enum logic [1:0] {IDLE, SHIFT, GAP} state_e;

	////////////////////////////////////////////////////////////////////////
	// Sampling of the returned serial data
	logic sdo_s1_q, sdo_s2_q;
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			sdo_s1_q <= 1'b1;
			sdo_s2_q <= 1'b1;
		end
		else
		begin
			sdo_s1_q <= LINK.sdo;
			sdo_s2_q <= sdo_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte sequencer; clock made by dividing CLOCK by four
	state_e st_q, st_d;
	logic [2:0] div_q, div_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic cs_q, cs_d, sck_q, sck_d, busy_q, busy_d, next_q, next_d, err_q, err_d;
	logic last_q, last_d;
	always_comb
	begin
		st_d = st_q;
		div_d = div_q;
		bit_d = bit_q;
		sh_d = sh_q;
		cs_d = cs_q;
		sck_d = sck_q;
		next_d = 1'b0;
		err_d = err_q;
		last_d = last_q;
		busy_d = busy_q;
		case (st_q)
			IDLE:
			begin
				if (START)
				begin
					st_d = SHIFT;
					sh_d = COMMAND;
					last_d = LAST;
					cs_d = 1'b0;
					busy_d = 1'b1;
					bit_d = 3'h0;
					div_d = 3'h0;
					err_d = 1'b0;
				end
			end
			SHIFT:
			begin
				div_d = div_q + 3'h1;
				if (div_q == LINK_DIV_HALF)
					sck_d = 1'b1;
				if (div_q == LINK_DIV_LAST)
				begin
					sck_d = 1'b0;
					div_d = 3'h0;
					if (!sdo_s2_q)
						err_d = 1'b1;
					sh_d = {sh_q[6:0], 1'b0};
					bit_d = bit_q + 3'h1;
					if (bit_q == CMD_WIDTH_LAST[2:0])
						st_d = GAP;
				end
			end
			GAP:
			begin
				// Deselect right after the last wanted step
				if (last_q)
				begin
					cs_d = 1'b1; // see (R15)
					busy_d = 1'b0;
					st_d = IDLE;
				end
				else if (START)
				begin
					// Chain the next byte under the same select
					st_d = SHIFT; // see (R4) (R13)
					sh_d = COMMAND;
					last_d = LAST;
					bit_d = 3'h0;
					div_d = 3'h0;
				end
				else
					next_d = ~next_q;
			end
			default: st_d = IDLE;
		endcase
	end
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			st_q <= IDLE;
			div_q <= 3'h0;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			cs_q <= 1'b1;
			sck_q <= 1'b0;
			busy_q <= 1'b0;
			next_q <= 1'b0;
			err_q <= 1'b0;
			last_q <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
			div_q <= div_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			cs_q <= cs_d;
			sck_q <= sck_d;
			busy_q <= busy_d;
			next_q <= next_d & (st_d == GAP);
			err_q <= err_d;
			last_q <= last_d;
		end
	end
	assign LINK.cs_n = cs_q;
	assign LINK.sck = sck_q;
	assign LINK.sdi = sh_q[7];
	assign BUSY = busy_q;
	assign NEXT = next_q;
	assign ERROR_SEEN = err_q;
endmodule // wiper_host
`default_nettype wire

// ---- testbench/spi_wiper_step_commands_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_wiper_step_commands_bench;
	import wiper_pkg::*;
	logic CLOCK;
	logic RST;
	logic start;
	logic last;
	logic [7:0] command;
	logic [7:0] wiper;
	logic cmd_error;
	logic busy;
	logic next;
	logic [7:0] model_q;
	logic [7:0] model_seven_q;
	logic [7:0] wiper_seven;
	logic cmd_error_seven;
	logic error_seen;
	logic done;
	int steps;
	logic err_q;
	logic [7:0] c;
	logic [31:0] r;
	int miscompares;
	int total_checks;
	int seed;
	wiper_link_if link();
	wiper_device wiper_device_i (.CLOCK(CLOCK), .RST(RST), .LINK(link.device), .WIPER(wiper),
		.STEP_DONE(done), .CMD_ERROR(cmd_error));
	wiper_host wiper_host_i (.CLOCK(CLOCK), .RST(RST), .LINK(link.host), .START(start),
		.COMMAND(command), .LAST(last), .BUSY(busy), .NEXT(next), .ERROR_SEEN(error_seen));
	// A seven-bit part listens to the same frames; its answer line goes nowhere
	wiper_link_if link_seven();
	assign link_seven.cs_n = link.cs_n;
	assign link_seven.sck = link.sck;
	assign link_seven.sdi = link.sdi;
	wiper_device #(.SEVEN_BIT(1'b1)) wiper_device_seven_i (.CLOCK(CLOCK), .RST(RST),
		.LINK(link_seven.device), .WIPER(wiper_seven), .STEP_DONE(),
		.CMD_ERROR(cmd_error_seven));
	wiper_link_sva wiper_link_sva_i (.CLOCK(CLOCK), .RST(RST), .cs_n(link.cs_n),
		.sck(link.sck), .sdi(link.sdi), .sdo(link.sdo));
	////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t flag got %b expected %b", $time, got, exp);
		end
	endtask
	// Saturating step, the expected wiper after one good command
	function automatic logic [7:0] stepped(input logic [7:0] w, input logic [1:0] op,
		input logic [7:0] top);
		if (op == OP_INCR && w != top)
			return w + 8'h01;
		if (op == OP_DECR && w != ZERO_SCALE)
			return w - 8'h01;
		return w;
	endfunction
	// One command byte; the device settles within a few cycles of the gap
	task automatic send(input logic [7:0] cmd, input logic fin);
		int n;
		int s0;
		logic ok;
		n = 0;
		while (busy && !next && n < 400)
		begin
			@(posedge CLOCK);
			n++;
		end
		s0 = steps;
		start <= 1'b1;
		command <= cmd;
		last <= fin;
		@(posedge CLOCK);
		start <= 1'b0;
		@(posedge CLOCK);
		n = 0;
		while (busy && !next && n < 400)
		begin
			@(posedge CLOCK);
			n++;
		end
		repeat (8) @(posedge CLOCK);
		ok = !err_q && cmd[7:4] == WIPER_ADDR && (cmd[3:2] inside {OP_INCR, OP_DECR});
		if (ok)
		begin
			model_q = stepped(model_q, cmd[3:2], FULL_SCALE_8);
			model_seven_q = stepped(model_seven_q, cmd[3:2], FULL_SCALE_7);
		end
		else
			err_q = 1'b1;
		chk(wiper, model_q);
		chk(wiper_seven, model_seven_q);
		chk(8'(steps - s0), {7'h00, ok});
		chk_bit(cmd_error, err_q && !fin);
		chk_bit(cmd_error_seven, err_q && !fin);
		chk_bit(error_seen, err_q);
		if (fin)
			err_q = 1'b0;
	endtask
	////////////////////////////////////////
	initial
	begin
		CLOCK = 1'b0;
		forever #25 CLOCK = ~CLOCK;
	end
	// Count step pulses, so each accepted byte is seen to move the wiper exactly once
	always @(posedge CLOCK)
	begin
		if (done)
			steps <= steps + 1;
	end
	// Watchdog, well beyond the roughly 29000 cycles the run needs
	initial
	begin
		repeat (80000) @(posedge CLOCK);
		miscompares++;
		end_of_test();
	end
	initial
	begin
		seed = 3001;
		RST = 1'b1;
		start = 1'b0;
		last = 1'b0;
		command = 8'h00;
		model_q = WIPER_RESET;
		model_seven_q = WIPER_RESET_7;
		err_q = 1'b0;
		repeat (10) @(posedge CLOCK);
		RST <= 1'b0;
		repeat (4) @(posedge CLOCK);
		// Long chains run into both saturation ends
		for (int i = 0; i < 130; i++)
			send({WIPER_ADDR, OP_INCR, 2'h0}, i == 129);
		for (int i = 0; i < 260; i++)
			send({WIPER_ADDR, OP_DECR, 2'h3}, i == 259);
		// Reset between frames brings both wipers back to their start values
		RST <= 1'b1;
		repeat (10) @(posedge CLOCK);
		RST <= 1'b0;
		repeat (4) @(posedge CLOCK);
		model_q = WIPER_RESET;
		model_seven_q = WIPER_RESET_7;
		chk(wiper, model_q);
		chk(wiper_seven, model_seven_q);
		// Random mixes, many aimed at address zero with a step opcode
		for (int i = 0; i < 300; i++)
		begin
			r = $random(seed);
			c = r[7:0];
			if (r[8])
				c[7:4] = WIPER_ADDR;
			if (r[12])
				c[3] = ~c[2];
			send(c, r[11:9] == 3'h0);
		end
		send({WIPER_ADDR, OP_INCR, 2'h0}, 1'b1);
		end_of_test();
	end
endmodule // spi_wiper_step_commands_bench
`default_nettype wire

// ---- testbench/wiper_link_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module wiper_link_sva (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo
);
	logic [2:0] bits_d;
	logic [2:0] bits_q;
	logic sck_q;
	// Serial clock rises within a select, modulo one byte
	always_comb
	begin
		bits_d = bits_q;
		if (cs_n)
			bits_d = 3'h0;
		else if (sck && !sck_q)
			bits_d = bits_q + 3'h1;
	end
	always_ff @(posedge CLOCK)
	begin
		sck_q <= RST ? 1'b0 : sck;
		bits_q <= RST ? 3'h0 : bits_d;
	end
	////////////////////////////////////////
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	a_idle_clock_low: assert property (cs_n |-> !sck)
		else $error("serial clock high while deselected");
	a_whole_bytes: assert property ($rose(cs_n) |-> bits_q == 3'h0)
		else $error("select released inside a byte");
	a_err_bit_place: assert property ($fell(sdo) |-> !cs_n && bits_q inside {3'h6, 3'h7})
		else $error("error flag off its bit slot");
	// Eight low cycles first, so a stale flag from the last frame is past
	a_err_sticky: assert property ((!cs_n)[*8] ##0 !sdo |=> !sdo || cs_n)
		else $error("error flag released under select");
	a_err_clears: assert property ($rose(cs_n) |-> ##[1:6] sdo)
		else $error("error flag kept after deselect");
	a_sdi_steady: assert property (sck && $past(sck) |-> $stable(sdi))
		else $error("data moved while clock high");
	a_sck_pulse: assert property ($rose(sck) |=> sck ##1 !sck)
		else $error("clock pulse width wrong");
	a_sck_in_frame: assert property ($rose(sck) |-> (!cs_n)[*3])
		else $error("clock pulse outside select");
endmodule // wiper_link_sva
`default_nettype wire
